// ---- logic/xisc_regs.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module xisc_regs
    import xisc_pkg::*;
#(
    parameter logic [15:0] CS3_BASE_MIN = 16'h0100,
    parameter logic [15:0] CS3_BASE_MAX = 16'h0FFC
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic main_power_reset,
    input wire logic hard_reset,
    input wire logic soft_reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire xisc_io_req_t io_req,
    output logic lpc_wait_sync,
    output logic io_done,
    output logic smbus_select,
    output logic expansion_chip_select_3_n,
    output logic xbus_read_n,
    output logic xbus_write_n,
    output logic xbus_mode_2,
    input wire logic ext_irq_input_a,
    input wire logic ext_irq_input_b,
    input wire logic ext_irq_input_c,
    input wire logic ext_irq_input_d,
    input wire logic smi_request,
    output logic sys_mgmt_irq_out_n,
    output logic [15:0] serial_irq_req,
    output logic slow_clock_absent,
    output logic key_wake_off
);

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] ldn;
    logic [7:0] cs3_high;
    logic [7:0] cs3_low;
    logic [7:0] xsel;
    logic [7:0] slowclk;
    logic [7:0] route_ab;
    logic [7:0] route_cd;
    logic [7:0] smb_high;
    logic [7:0] smb_low;
    logic [3:0] irq_meta;
    logic [3:0] irq_sync;
    logic [15:0] routed;

    function automatic logic reg_hit(input logic [7:0] cur_ldn, input logic [7:0] dev,
                                     input logic [7:0] addr, input logic [7:0] idx);
        return (cur_ldn == dev) && (addr == idx);
    endfunction

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire hit_ldn = (reg_addr == IDX_LDN);
    wire hit_cs3_high = reg_hit(ldn, LDN_XBUS, reg_addr, IDX_CS3_HIGH);
    wire hit_cs3_low = reg_hit(ldn, LDN_XBUS, reg_addr, IDX_CS3_LOW);
    wire hit_xsel = reg_hit(ldn, LDN_XBUS, reg_addr, IDX_XBUS_SEL);
    wire hit_slow = reg_hit(ldn, LDN_RUNTIME, reg_addr, IDX_SLOW_CLK);
    wire hit_route_ab = reg_hit(ldn, LDN_RUNTIME, reg_addr, IDX_ROUTE_AB);
    wire hit_route_cd = reg_hit(ldn, LDN_RUNTIME, reg_addr, IDX_ROUTE_CD);
    wire hit_smb_high = reg_hit(ldn, LDN_SMBUS, reg_addr, IDX_SMB_HIGH);
    wire hit_smb_low = reg_hit(ldn, LDN_SMBUS, reg_addr, IDX_SMB_LOW);

    wire cs3_locked = cs3_low[CS3_WP_BIT];
    wire xsel_locked = xsel[XSEL_WP_BIT];
    wire wr_cs3_high = reg_wr && hit_cs3_high && !cs3_locked;
    wire wr_cs3_low = reg_wr && hit_cs3_low && !cs3_locked;
    wire wr_xsel = reg_wr && hit_xsel && !xsel_locked;
    wire wp_clear = main_power_reset || hard_reset;
    wire cfg_clear = main_power_reset || hard_reset || soft_reset;

    // ****************************************************************
    // next values
    // ****************************************************************
    // write protect only ever goes to one from software
    wire [7:0] next_xsel_low = wr_xsel ? (reg_wdata & XSEL_WMASK) : (xsel & XSEL_WMASK);
    wire next_xsel_wp = !wp_clear && (xsel_locked || (wr_xsel && reg_wdata[XSEL_WP_BIT]));
    wire next_cs3_wp = !wp_clear && (cs3_locked || (wr_cs3_low && reg_wdata[CS3_WP_BIT]));
    wire [7:0] next_cs3_low_data = cfg_clear ? REG_RESET :
                                   wr_cs3_low ? reg_wdata : cs3_low;
    wire [7:0] next_rdata =
        !reg_rd ? 8'h00 :
        hit_ldn ? ldn :
        hit_cs3_high ? cs3_high :
        hit_cs3_low ? cs3_low :
        hit_xsel ? xsel :
        hit_slow ? slowclk :
        hit_route_ab ? route_ab :
        hit_route_cd ? route_cd :
        hit_smb_high ? smb_high :
        hit_smb_low ? smb_low : 8'h00;

    // ****************************************************************
    // register file
    // ****************************************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ldn <= REG_RESET;
            xsel <= REG_RESET;
            slowclk <= REG_RESET;
            route_ab <= REG_RESET;
            route_cd <= REG_RESET;
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
            if (reg_wr && hit_ldn)
                ldn <= reg_wdata;
            xsel <= {next_xsel_wp, next_xsel_low[6:0]};
            if (reg_wr && hit_slow)
                slowclk <= reg_wdata & SLOW_WMASK;
            if (reg_wr && hit_route_ab)
                route_ab <= reg_wdata;
            if (reg_wr && hit_route_cd)
                route_cd <= reg_wdata;
        end
    end

    // these follow every reset, not only standby power-on; the cs3_low write-protect bit follows main power and hard reset only
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cs3_high <= REG_RESET;
            cs3_low <= REG_RESET;
            smb_high <= REG_RESET;
            smb_low <= REG_RESET;
        end
        else
        begin
            if (cfg_clear)
                cs3_high <= REG_RESET;
            else if (wr_cs3_high)
                cs3_high <= reg_wdata;
            cs3_low <= {next_cs3_low_data[7:2], next_cs3_wp, next_cs3_low_data[0]};
            if (cfg_clear)
            begin
                smb_high <= REG_RESET;
                smb_low <= REG_RESET;
            end
            else
            begin
                if (reg_wr && hit_smb_high)
                    smb_high <= reg_wdata & SMB_HIGH_WMASK;
                if (reg_wr && hit_smb_low)
                    smb_low <= reg_wdata & SMB_LOW_WMASK;
            end
        end
    end

    // ****************************************************************
    // address matching
    // ****************************************************************
    wire [15:0] cs3_base = {cs3_high, cs3_low[7:2], 2'b00};
    wire [15:0] smb_base = {4'h0, smb_high[3:0], smb_low[7:3], 3'b000};
    wire cs3_base_ok = (cs3_base >= CS3_BASE_MIN) && (cs3_base <= CS3_BASE_MAX);
    wire smb_base_ok = (smb_base >= SMB_BASE_MIN) && (smb_base <= SMB_BASE_MAX);
    wire mode_1 = !xsel[XSEL_MODE_BIT];
    // every address bit above the decoded window is compared, so a stray upper nibble never aliases
    wire cs3_match = ((io_req.addr & CS3_MATCH_MASK) == cs3_base);
    wire smb_match = ((io_req.addr & SMB_MATCH_MASK) == smb_base);
    wire cs3_hit = io_req.start && mode_1 && cs3_match && cs3_base_ok
                   && !cs3_low[CS3_DISABLE_BIT];
    wire smb_hit = io_req.start && smb_match && smb_base_ok;

    xisc_strobe_timer u_timer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(cs3_hit),
        .write(io_req.write),
        .width_sel(xsel[XSEL_WIDTH_LSB +: 2]),
        .sel_n(expansion_chip_select_3_n),
        .read_n(xbus_read_n),
        .write_n(xbus_write_n),
        .stretch(lpc_wait_sync),
        .done(io_done)
    );

    // ****************************************************************
    // interrupt routing
    // ****************************************************************
    xisc_irq_router #(
        .NUM_IN(4)
    ) u_router (
        .routes({route_cd, route_ab}),
        .irq_level(irq_sync),
        .serial_irq(routed)
    );

    // serial interrupt 2 is shared with the SMI request
    wire [15:0] next_serial_irq = routed | {13'h0000, smi_request, 2'b00};

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_meta <= 4'h0;
            irq_sync <= 4'h0;
            serial_irq_req <= 16'h0000;
            sys_mgmt_irq_out_n <= 1'b1;
            smbus_select <= 1'b0;
            xbus_mode_2 <= 1'b0;
            slow_clock_absent <= 1'b0;
            key_wake_off <= 1'b0;
        end
        else
        begin
            irq_meta <= {ext_irq_input_d, ext_irq_input_c, ext_irq_input_b, ext_irq_input_a};
            irq_sync <= irq_meta;
            serial_irq_req <= next_serial_irq;
            sys_mgmt_irq_out_n <= !smi_request;
            smbus_select <= smb_hit;
            xbus_mode_2 <= xsel[XSEL_MODE_BIT];
            slow_clock_absent <= slowclk[SLOW_ABSENT_BIT];
            key_wake_off <= slowclk[KEY_OFF_BIT];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    logic [7:0] low_cnt;
    logic [6:0] exp_cycles;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt <= 8'h00;
            exp_cycles <= 7'h00;
        end
        else
        begin
            low_cnt <= expansion_chip_select_3_n ? 8'h00 : low_cnt + 8'h01;
            if (cs3_hit && expansion_chip_select_3_n)
                exp_cycles <= strobe_cycles(xsel[XSEL_WIDTH_LSB +: 2]);
        end
    end

    cs3_disable_a: assert property (
        (io_req.start && cs3_low[CS3_DISABLE_BIT] && expansion_chip_select_3_n)
        |=> expansion_chip_select_3_n)
        else $error("chip select 3 asserted while disabled");
    mode_gate_a: assert property (
        (io_req.start && xsel[XSEL_MODE_BIT] && expansion_chip_select_3_n)
        |=> expansion_chip_select_3_n)
        else $error("chip select 3 asserted in mode 2");
    strobe_width_a: assert property (
        $rose(expansion_chip_select_3_n) |-> (low_cnt == {1'b0, exp_cycles}))
        else $error("strobe width differs from programmed minimum");
    wait_cover_a: assert property (
        !expansion_chip_select_3_n |-> lpc_wait_sync ##0 !io_done)
        else $error("wait sync dropped during strobe");
    done_follow_a: assert property (
        $rose(expansion_chip_select_3_n) |-> io_done ##1 !io_done)
        else $error("cycle end not signalled once");
    sel_lock_a: assert property (
        (xsel_locked && reg_wr && hit_xsel && !wp_clear) |=> $stable(xsel))
        else $error("protected selection register changed");
    wp_sticky_a: assert property (
        (xsel_locked && !wp_clear) |=> xsel_locked)
        else $error("write protect cleared without reset");
    smb_fixed_a: assert property (
        smb_high[7:4] == 4'h0 && smb_low[2:0] == 3'h0)
        else $error("smbus base fixed bits nonzero");
    smb_range_a: assert property (
        (io_req.start && !smb_base_ok) |=> !smbus_select)
        else $error("smbus selected with base out of range");
    route_a_a: assert property (
        (route_ab[3:0] != 4'h0 && irq_sync[0]) |=> serial_irq_req[$past(route_ab[3:0])])
        else $error("input A not routed");
    route_d_a: assert property (
        (route_cd[7:4] != 4'h0 && irq_sync[3]) |=> serial_irq_req[$past(route_cd[7:4])])
        else $error("input D not routed");
    slow_read_a: assert property (
        (reg_rd && hit_slow) |=> reg_rdata[7:2] == 6'h00
        ##1 slow_clock_absent == $past(slowclk[0]))
        else $error("slow clock register reserved bits read nonzero");
    // outputs trail their register bits, and sys_mgmt_irq_out_n the inverted smi_request, by one flop
    mode_out_a: assert property (
        xbus_mode_2 == $past(xsel[XSEL_MODE_BIT]))
        else $error("mode output stale");
    absent_out_a: assert property (
        slow_clock_absent == $past(slowclk[SLOW_ABSENT_BIT]))
        else $error("absent output stale");
    key_out_a: assert property (
        key_wake_off == $past(slowclk[KEY_OFF_BIT]))
        else $error("key wake output stale");
    smi_out_a: assert property (
        sys_mgmt_irq_out_n == !$past(smi_request))
        else $error("smi output stale");
    route_c_a: assert property (
        (route_cd[3:0] != 4'h0 && irq_sync[2]) |=> serial_irq_req[$past(route_cd[3:0])])
        else $error("input C not routed");
    // one strobe per cycle, picked by the request direction
    strobe_dir_a: assert property (
        !expansion_chip_select_3_n |-> xbus_read_n != xbus_write_n)
        else $error("read and write strobes not exclusive");
    write_dir_a: assert property (
        $fell(expansion_chip_select_3_n) |-> xbus_write_n == !$past(io_req.write))
        else $error("strobe direction differs from request");

    strobe_done_c: cover property ($rose(expansion_chip_select_3_n) ##1 io_done);
    write_strobe_c: cover property ($fell(xbus_write_n));
    smb_select_c: cover property (smbus_select);
    wp_set_c: cover property ($rose(xsel_locked));
    irq_routed_c: cover property (|routed[15:1]);

endmodule
`default_nettype wire

// ---- logic/xisc_pkg.sv ----
package xisc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] IDX_LDN = 8'h07;
    localparam logic [7:0] LDN_XBUS = 8'h08;
    localparam logic [7:0] LDN_RUNTIME = 8'h0A;
    localparam logic [7:0] LDN_SMBUS = 8'h0B;
    localparam logic [7:0] IDX_CS3_HIGH = 8'h66;
    localparam logic [7:0] IDX_CS3_LOW = 8'h67;
    localparam logic [7:0] IDX_XBUS_SEL = 8'hF0;
    localparam logic [7:0] IDX_SLOW_CLK = 8'hF0;
    localparam logic [7:0] IDX_ROUTE_AB = 8'hF4;
    localparam logic [7:0] IDX_ROUTE_CD = 8'hF5;
    localparam logic [7:0] IDX_SMB_HIGH = 8'h60;
    localparam logic [7:0] IDX_SMB_LOW = 8'h61;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ****************************************************************
    // field positions and writable masks
    // ****************************************************************
    localparam int CS3_DISABLE_BIT = 0;
    localparam int CS3_WP_BIT = 1;
    localparam int XSEL_MODE_BIT = 0;
    localparam int XSEL_WIDTH_LSB = 2;
    localparam int XSEL_WP_BIT = 7;
    localparam int SLOW_ABSENT_BIT = 0;
    localparam int KEY_OFF_BIT = 1;
    localparam logic [7:0] XSEL_WMASK = 8'h0D;
    localparam logic [7:0] SLOW_WMASK = 8'h03;
    localparam logic [7:0] SMB_HIGH_WMASK = 8'h0F;
    localparam logic [7:0] SMB_LOW_WMASK = 8'hF8;
    localparam logic [15:0] CS3_MATCH_MASK = 16'hFFFC;
    localparam logic [15:0] SMB_MATCH_MASK = 16'hFFF8;
    localparam logic [15:0] SMB_BASE_MIN = 16'h0100;
    localparam logic [15:0] SMB_BASE_MAX = 16'h0FF8;

    // ****************************************************************
    // strobe timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int STROBE_NS_0 = 180;
    localparam int STROBE_NS_1 = 300;
    localparam int STROBE_NS_2 = 420;
    localparam int STROBE_NS_3 = 540;
    localparam int STROBE_CW = 7;
    localparam logic [6:0] STROBE_CYC_0 = 7'((STROBE_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] STROBE_CYC_1 = 7'((STROBE_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] STROBE_CYC_2 = 7'((STROBE_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] STROBE_CYC_3 = 7'((STROBE_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef struct packed {
        logic start;
        logic write;
        logic [15:0] addr;
    } xisc_io_req_t;

    function automatic logic [6:0] strobe_cycles(input logic [1:0] sel);
        logic [6:0] n;
        n = STROBE_CYC_0;
        unique case (sel)
            2'h0: n = STROBE_CYC_0;
            2'h1: n = STROBE_CYC_1;
            2'h2: n = STROBE_CYC_2;
            2'h3: n = STROBE_CYC_3;
        endcase
        return n;
    endfunction

endpackage

// ---- logic/xisc_strobe_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module xisc_strobe_timer
    import xisc_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic write,
    input wire logic [1:0] width_sel,
    output logic sel_n,
    output logic read_n,
    output logic write_n,
    output logic stretch,
    output logic done
);

    logic [STROBE_CW-1:0] count;
    wire accept = start && sel_n;
    wire last = !sel_n && (count == '0);

    // starts while a strobe runs are dropped; the host is held by stretch
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            sel_n <= 1'b1;
            read_n <= 1'b1;
            write_n <= 1'b1;
            stretch <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= last;
            if (accept)
            begin
                count <= strobe_cycles(width_sel) - 7'h01;
                sel_n <= 1'b0;
                read_n <= write;
                write_n <= !write;
                stretch <= 1'b1;
            end
            else if (last)
            begin
                sel_n <= 1'b1;
                read_n <= 1'b1;
                write_n <= 1'b1;
                stretch <= 1'b0;
            end
            else if (!sel_n)
            begin
                count <= count - 7'h01;
            end
        end
    end

endmodule
`default_nettype wire

// ---- logic/xisc_irq_router.sv ----
`timescale 1ns/1ps
`default_nettype none
module xisc_irq_router
    import xisc_pkg::*;
#(
    parameter int NUM_IN = 4
)
(
    input wire logic [4*NUM_IN-1:0] routes,
    input wire logic [NUM_IN-1:0] irq_level,
    output logic [15:0] serial_irq
);

    // field value 0 selects nothing, so bit 0 is never driven
    function automatic logic [15:0] route_decode(input logic [3:0] field);
        logic [15:0] d;
        d = 16'h0001 << field;
        return {d[15:1], 1'b0};
    endfunction

    logic [15:0] per_in [NUM_IN];

    genvar i;
    generate
        for (i = 0; i < NUM_IN; i++)
        begin : g_in
            assign per_in[i] = irq_level[i] ? route_decode(routes[4*i +: 4]) : 16'h0000;
        end
    endgenerate

    always_comb
    begin
        serial_irq = 16'h0000;
        for (int k = 0; k < NUM_IN; k++)
        begin
            serial_irq = serial_irq | per_in[k];
        end
    end

endmodule
`default_nettype wire

// ---- verif/xisc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host side: issues decoded io cycles, counts what comes back
// ****************************************************************
module xisc_host_model
    import xisc_pkg::*;
(
    input wire logic core_clk,
    output xisc_io_req_t io_req,
    input wire logic lpc_wait_sync,
    input wire logic io_done,
    input wire logic smbus_select,
    input wire logic expansion_chip_select_3_n
);
    initial io_req = '0;

    // start is a one-cycle pulse; next start waits for io_done or give-up
    task automatic run(input logic [15:0] a, input logic w, output int n_cs, output int n_wait,
        output int n_sel, output int n_done);
        n_cs = 0;
        n_wait = 0;
        n_sel = 0;
        n_done = 0;
        @(posedge core_clk);
        io_req <= '{start: 1'b1, write: w, addr: a};
        @(posedge core_clk);
        io_req.start <= 1'b0;
        // bounded: a miss never answers with io_done
        for (int i = 0; i < 90 && n_done == 0; i++)
        begin
            #1;
            n_cs += int'(expansion_chip_select_3_n === 1'b0);
            n_wait += int'(lpc_wait_sync === 1'b1);
            n_sel += int'(smbus_select === 1'b1);
            n_done += int'(io_done === 1'b1);
            @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/xisc_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module xisc_regs_tb
    import xisc_pkg::*;
;
    logic core_clk, arst_n, main_power_reset, hard_reset, soft_reset, reg_wr, reg_rd;
    logic ext_irq_input_a, ext_irq_input_b, ext_irq_input_c, ext_irq_input_d, smi_request;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    xisc_io_req_t io_req;
    logic lpc_wait_sync, io_done, smbus_select, expansion_chip_select_3_n, xbus_read_n;
    logic xbus_write_n, xbus_mode_2, sys_mgmt_irq_out_n, slow_clock_absent, key_wake_off;
    logic [15:0] serial_irq_req;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int ncs, nw, ns, nd, nrd, nwr, r0, w0;

    xisc_regs xisc_regs_i (.core_clk(core_clk), .arst_n(arst_n),
        .main_power_reset(main_power_reset), .hard_reset(hard_reset), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .io_req(io_req), .lpc_wait_sync(lpc_wait_sync),
        .io_done(io_done), .smbus_select(smbus_select),
        .expansion_chip_select_3_n(expansion_chip_select_3_n), .xbus_read_n(xbus_read_n),
        .xbus_write_n(xbus_write_n), .xbus_mode_2(xbus_mode_2),
        .ext_irq_input_a(ext_irq_input_a), .ext_irq_input_b(ext_irq_input_b),
        .ext_irq_input_c(ext_irq_input_c), .ext_irq_input_d(ext_irq_input_d),
        .smi_request(smi_request), .sys_mgmt_irq_out_n(sys_mgmt_irq_out_n),
        .serial_irq_req(serial_irq_req), .slow_clock_absent(slow_clock_absent),
        .key_wake_off(key_wake_off));

    xisc_host_model xisc_host_model_i (.core_clk(core_clk), .io_req(io_req),
        .lpc_wait_sync(lpc_wait_sync), .io_done(io_done), .smbus_select(smbus_select),
        .expansion_chip_select_3_n(expansion_chip_select_3_n));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(nm, {8'h00, reg_rdata}, {8'h00, e});
    endtask

    task automatic sync_rst(input int k);
        @(posedge core_clk);
        main_power_reset <= (k == 0);
        hard_reset <= (k == 1);
        soft_reset <= (k == 2);
        @(posedge core_clk);
        {main_power_reset, hard_reset, soft_reset} <= 3'h0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        check("cs3 idle", {15'h0, expansion_chip_select_3_n}, 16'h0001);
        check("irq idle", serial_irq_req, 16'h0000);
        wr(IDX_LDN, LDN_XBUS);
        rd_chk(IDX_XBUS_SEL, 8'h00, "xsel rst");
        wr(IDX_LDN, LDN_RUNTIME);
        rd_chk(IDX_SLOW_CLK, 8'h00, "slow rst");
        rd_chk(IDX_ROUTE_AB, 8'h00, "ab rst");
        rd_chk(IDX_ROUTE_CD, 8'h00, "cd rst");
        $display("test reset done");
    endtask

    task automatic t_strobe();
        wr(IDX_LDN, LDN_XBUS);
        wr(IDX_CS3_HIGH, 8'h03);
        wr(IDX_CS3_LOW, 8'h00);
        for (int w = 0; w < 4; w++)
        begin
            wr(IDX_XBUS_SEL, 8'(w << 2));
            r0 = nrd;
            w0 = nwr;
            xisc_host_model_i.run(16'h0302, w[0], ncs, nw, ns, nd);
            // minimum ns rounded up to whole 8 ns cycles
            check("strobe len", 16'(ncs), 16'((180 + 120 * w + 7) / 8));
            check("wait syncs", 16'(nw), 16'(ncs));
            check("done", 16'(nd), 16'h0001);
            check("rd strobe", 16'(nrd - r0), w[0] ? 16'h0000 : 16'(ncs));
            check("wr strobe", 16'(nwr - w0), w[0] ? 16'(ncs) : 16'h0000);
        end
        xisc_host_model_i.run(16'h1302, 1'b0, ncs, nw, ns, nd);
        check("cs3 upper", 16'(ncs), 16'h0000);
        wr(IDX_CS3_LOW, 8'h01);
        xisc_host_model_i.run(16'h0302, 1'b0, ncs, nw, ns, nd);
        check("cs3 off", 16'(ncs), 16'h0000);
        wr(IDX_CS3_LOW, 8'h00);
        wr(IDX_XBUS_SEL, 8'h01);
        xisc_host_model_i.run(16'h0302, 1'b0, ncs, nw, ns, nd);
        check("mode2 pin", {15'h0, xbus_mode_2}, 16'h0001);
        check("cs3 mode2", 16'(ncs), 16'h0000);
        $display("test strobe done");
    endtask

    task automatic t_protect();
        wr(IDX_XBUS_SEL, 8'h72);
        rd_chk(IDX_XBUS_SEL, 8'h00, "xsel rsvd");
        wr(IDX_XBUS_SEL, 8'h8D);
        wr(IDX_XBUS_SEL, 8'h00);
        rd_chk(IDX_XBUS_SEL, 8'h8D, "xsel locked");
        sync_rst(2);
        rd_chk(IDX_XBUS_SEL, 8'h8D, "soft keeps");
        sync_rst(0);
        rd_chk(IDX_XBUS_SEL, 8'h0D, "main clears");
        wr(IDX_XBUS_SEL, 8'h84);
        sync_rst(1);
        rd_chk(IDX_XBUS_SEL, 8'h04, "hard clears");
        $display("test protect done");
    endtask

    task automatic t_slow();
        wr(IDX_LDN, LDN_RUNTIME);
        wr(IDX_SLOW_CLK, 8'hFF);
        rd_chk(IDX_SLOW_CLK, 8'h03, "slow rsvd");
        check("absent", {15'h0, slow_clock_absent}, 16'h0001);
        wr(IDX_SLOW_CLK, 8'h02);
        rd_chk(IDX_SLOW_CLK, 8'h02, "slow rd");
        check("absent off", {15'h0, slow_clock_absent}, 16'h0000);
        check("key off", {15'h0, key_wake_off}, 16'h0001);
        $display("test slow clock done");
    endtask

    task automatic t_route();
        // serial interrupt 2 is reused below, so the smi request stays quiet
        smi_request <= 1'b0;
        for (int v = 0; v < 16; v++)
        begin
            wr(IDX_ROUTE_AB, 8'(v));
            ext_irq_input_a <= 1'b1;
            repeat (4) @(posedge core_clk);
            #1;
            check("route a", serial_irq_req, (v == 0) ? 16'h0000 : 16'(1 << v));
            ext_irq_input_a <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        wr(IDX_ROUTE_AB, 8'h50);
        wr(IDX_ROUTE_CD, 8'h9C);
        {ext_irq_input_b, ext_irq_input_c, ext_irq_input_d} <= 3'h7;
        repeat (4) @(posedge core_clk);
        #1;
        check("route bcd", serial_irq_req, 16'h1220);
        {ext_irq_input_b, ext_irq_input_c, ext_irq_input_d} <= 3'h0;
        smi_request <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check("smi pin", {15'h0, sys_mgmt_irq_out_n}, 16'h0000);
        check("smi irq2", serial_irq_req, 16'h0004);
        smi_request <= 1'b0;
        $display("test route done");
    endtask

    task automatic t_smbus();
        wr(IDX_LDN, LDN_SMBUS);
        wr(IDX_SMB_HIGH, 8'hFF);
        rd_chk(IDX_SMB_HIGH, 8'h0F, "smb high");
        wr(IDX_SMB_LOW, 8'hFF);
        rd_chk(IDX_SMB_LOW, 8'hF8, "smb low");
        // host keeps the base inside its legal range here
        wr(IDX_SMB_HIGH, 8'h01);
        wr(IDX_SMB_LOW, 8'h20);
        xisc_host_model_i.run(16'h0125, 1'b0, ncs, nw, ns, nd);
        check("smb hit", 16'(ns), 16'h0001);
        xisc_host_model_i.run(16'h1125, 1'b0, ncs, nw, ns, nd);
        check("smb upper", 16'(ns), 16'h0000);
        wr(IDX_SMB_HIGH, 8'h00);
        wr(IDX_SMB_LOW, 8'h08);
        xisc_host_model_i.run(16'h000A, 1'b0, ncs, nw, ns, nd);
        check("smb range", 16'(ns), 16'h0000);
        $display("test smbus done");
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        nrd += int'(xbus_read_n === 1'b0);
        nwr += int'(xbus_write_n === 1'b0);
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end

    initial
    begin
        {main_power_reset, hard_reset, soft_reset, reg_wr, reg_rd, smi_request} = 6'h00;
        {ext_irq_input_a, ext_irq_input_b, ext_irq_input_c, ext_irq_input_d} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        arst_n = 1'b0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_strobe();
        t_protect();
        t_slow();
        t_route();
        t_smbus();
        close_out();
    end
endmodule
`default_nettype wire
